// File: rtl/tag_state_machine.sv
`timescale 1ns/1ps
// Contract
// - Each state acts only on its own commands; others change only the write slot_advance_cmd count.
// - Data group select/deselect compare equal, not equal, greater, less.
// - Flag group select/deselect compare only equal or not equal.
// - Ready plus matching group select goes to identify, else stays.
// - Reinit returns to ready and clears the exchange-seen bit.
// - Ready plus ID-addressed command with ID match enters exchange.
// - Identify plus ID commands or identified read with match enters exchange.
// - Quad verify read enters exchange only on ID match and write slot_advance_cmd.
// - Identify plus matching group deselect returns to ready.
// - Bulk-write deselect needs equal written data and write slot_advance_cmd.
// - Exchange stays in exchange for reads, writes, protect commands.
// - Flag byte reached only by flag group commands through byte mask.
// - Flag byte is eight bits, upper six bits read zero.
// - Bit zero is exchange-seen, bit one is write slot_advance_cmd.
// - Exchange-seen set on entering exchange, kept until reinit or retention timeout.
// - Power-off with seen bit set starts retention timer clearing it.
// - Return to ready with seen bit still set stops timer, keeps bit.
// - After reset the tag falls to power-off until the synchronised field is present, then sits in ready.
// - Write slot_advance_cmd set by good programming, dropped by second command.
module tag_state_machine #(
  parameter int unsigned RETENTION_CYCLES = tsm_pkg::SEEN_RETENTION_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_field_present,
  input wire logic i_cmd_valid,
  input wire tsm_pkg::cmd_t i_cmd,
  input wire tsm_pkg::cmp_t i_cmp,
  input wire logic i_id_match,
  input wire logic i_data_eq,
  input wire logic i_data_gt,
  input wire logic i_bulk_data_match,
  input wire logic [7:0] i_flag_mask,
  input wire logic [7:0] i_flag_value,
  input wire logic i_prog_done,
  input wire logic i_prog_ok,
  output tsm_pkg::tag_state_t o_state,
  output logic [7:0] o_flag_byte,
  output logic o_cmd_taken,
  output logic o_cmd_ignored
);
  import tsm_pkg::*;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic data_criterion(input cmp_t cmp,
                                          input logic eq,
                                          input logic gt);
    logic res;
    res = 1'b0;
    case (cmp)
      cmp_eq: res = eq;
      cmp_ne: res = !eq;
      cmp_gt: res = gt;
      cmp_lt: res = !eq && !gt;
      default: res = 1'b0;
    endcase
    return res;
  endfunction : data_criterion

  function automatic logic is_id_cmd(input cmd_t cmd);
    logic res;
    res = 1'b0;
    case (cmd)
      cmd_read, cmd_byte_write, quad_byte_write, protect_query_cmd,
      cmd_port_read, variable_length_fetch: res = 1'b1;
      default: res = 1'b0;
    endcase
    return res;
  endfunction : is_id_cmd

  function automatic logic is_exchange_cmd(input cmd_t cmd);
    logic res;
    res = 1'b0;
    case (cmd)
      cmd_read, cmd_identified_read, cmd_verify_read, quad_verify_read,
      cmd_port_read, variable_length_fetch, cmd_byte_write,
      cmd_broadcast_byte_write, quad_byte_write, broadcast_quad_write,
      cmd_protect, protect_query_cmd: res = 1'b1;
      default: res = 1'b0;
    endcase
    return res;
  endfunction : is_exchange_cmd

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    tag_state_t state;
    logic seen;
    logic wok;
    logic wok_armed;
    logic [WOK_CNT_W-1:0] cmds_after;
    logic taken;
    logic ignored;
    logic field_meta;
    logic field_sync;
    logic timer_start;
    logic timer_stop;
  } top_st_t;

  top_st_t s_q;
  top_st_t s_d;

  seen_timer_if tmr ();

  logic flag_cmp_ok;
  logic flag_hit;
  logic data_hit;
  logic [7:0] flag_byte;

  always_comb begin
    flag_byte = FLAG_RESET;
    flag_byte[FLAG_SEEN_POS] = s_q.seen;
    flag_byte[FLAG_WOK_POS] = s_q.wok;
  end

  flag_match u_flag_match (
    .i_flags(flag_byte),
    .i_mask(i_flag_mask),
    .i_value(i_flag_value),
    .i_cmp(i_cmp),
    .o_valid_cmp(flag_cmp_ok),
    .o_match(flag_hit)
  );

  seen_timer #(
    .RETENTION_CYCLES(RETENTION_CYCLES)
  ) u_seen_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .bus(tmr.timer)
  );

  assign data_hit = data_criterion(i_cmp, i_data_eq, i_data_gt);
  assign tmr.start = s_q.timer_start;
  assign tmr.stop = s_q.timer_stop;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic act;
    logic go_exch;
    act = 1'b0;
    go_exch = 1'b0;
    s_d = s_q;
    s_d.taken = 1'b0;
    s_d.ignored = 1'b0;
    s_d.timer_start = 1'b0;
    s_d.timer_stop = 1'b0;
    // Field level is asynchronous to the oscillator
    s_d.field_meta = i_field_present;
    s_d.field_sync = s_q.field_meta;

    if (s_q.state == st_power_off) begin
      if (s_q.field_sync) begin
        s_d.state = st_ready;
        s_d.timer_stop = s_q.seen;
      end
    end else if (!s_q.field_sync) begin
      s_d.state = st_power_off;
      s_d.wok = 1'b0; // Supply loss voids the write result
      s_d.wok_armed = 1'b0;
      s_d.timer_start = s_q.seen;
    end else if (i_cmd_valid) begin
      case (s_q.state)
        st_ready: begin
          case (i_cmd)
            group_select_by_data: begin
              act = 1'b1;
              if (data_hit) begin
                s_d.state = identify_state;
              end
            end
            group_select_by_flags: begin
              act = flag_cmp_ok;
              if (flag_cmp_ok && flag_hit) begin
                s_d.state = identify_state;
              end
            end
            cmd_reinit: begin
              act = 1'b1;
            end
            quad_verify_read: begin
              act = 1'b1;
              go_exch = i_id_match && s_q.wok;
            end
            default: begin
              act = is_id_cmd(i_cmd);
              go_exch = act && i_id_match;
            end
          endcase
        end
        identify_state: begin
          case (i_cmd)
            group_select_by_data, cmd_collision_retry, slot_advance_cmd,
            repeat_reply_cmd, cmd_broadcast_byte_write,
            broadcast_quad_write: begin
              act = 1'b1;
            end
            group_select_by_flags: begin
              act = flag_cmp_ok;
            end
            group_deselect_by_data: begin
              act = 1'b1;
              if (data_hit) begin
                s_d.state = st_ready;
              end
            end
            group_deselect_by_flags: begin
              act = flag_cmp_ok;
              if (flag_cmp_ok && flag_hit) begin
                s_d.state = st_ready;
              end
            end
            cmd_bulk_write_deselect: begin
              act = 1'b1;
              if (i_bulk_data_match && s_q.wok) begin
                s_d.state = st_ready;
              end
            end
            cmd_reinit: begin
              act = 1'b1;
            end
            cmd_identified_read: begin
              act = 1'b1;
              go_exch = i_id_match;
            end
            quad_verify_read: begin
              act = 1'b1;
              go_exch = i_id_match && s_q.wok;
            end
            default: begin
              act = is_id_cmd(i_cmd);
              go_exch = act && i_id_match;
            end
          endcase
        end
        st_exchange: begin
          act = (i_cmd == cmd_reinit) || is_exchange_cmd(i_cmd);
        end
        default: begin
          act = 1'b0;
        end
      endcase

      if (act && i_cmd == cmd_reinit) begin
        s_d.state = st_ready;
        s_d.seen = 1'b0;
      end
      if (go_exch) begin
        s_d.state = st_exchange;
      end
      s_d.taken = act;
      s_d.ignored = !act;

      // Any received command counts toward dropping write slot_advance_cmd
      if (s_q.wok_armed) begin
        if (s_q.cmds_after == WOK_CNT_W'(WOK_CLEAR_CMDS - 1)) begin
          s_d.wok = 1'b0;
          s_d.wok_armed = 1'b0;
        end else begin
          s_d.cmds_after = s_q.cmds_after + 1'b1;
        end
      end
    end

    // Entering exchange marks the tag as handled
    if (s_d.state == st_exchange) begin
      s_d.seen = 1'b1;
    end
    // Timer only runs with the tag unpowered, so no fresh set can race it
    if (tmr.expired && s_q.state == st_power_off) begin
      s_d.seen = 1'b0;
    end

    // A fresh programming result wins over the command count clear
    if (i_prog_done && s_q.state != st_power_off) begin
      s_d.wok = i_prog_ok;
      s_d.wok_armed = 1'b1;
      s_d.cmds_after = '0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.state <= st_ready;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_state = s_q.state;
  assign o_flag_byte = flag_byte;
  assign o_cmd_taken = s_q.taken;
  assign o_cmd_ignored = s_q.ignored;

endmodule : tag_state_machine

// File: inc/tsm_pkg.sv
package tsm_pkg;

  // ----------------------------------------
  // States and command set
  // ----------------------------------------
  typedef enum logic [1:0] {
    st_ready,
    identify_state,
    st_exchange,
    st_power_off
  } tag_state_t;

  typedef enum logic [4:0] {
    group_select_by_data,
    group_select_by_flags,
    group_deselect_by_data,
    group_deselect_by_flags,
    cmd_bulk_write_deselect,
    cmd_collision_retry,
    slot_advance_cmd,
    repeat_reply_cmd,
    cmd_reinit,
    cmd_read,
    cmd_identified_read,
    cmd_verify_read,
    quad_verify_read,
    cmd_byte_write,
    cmd_broadcast_byte_write,
    quad_byte_write,
    broadcast_quad_write,
    cmd_protect,
    protect_query_cmd,
    cmd_port_read,
    variable_length_fetch
  } cmd_t;

  typedef enum logic [1:0] {
    cmp_eq,
    cmp_ne,
    cmp_gt,
    cmp_lt
  } cmp_t;

  // ----------------------------------------
  // Flag byte layout
  // ----------------------------------------
  localparam int FLAG_WIDTH = 8;
  localparam int FLAG_SEEN_POS = 0;
  localparam int FLAG_WOK_POS = 1;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  // seen_bit_retention_time in milliseconds
  localparam int unsigned SEEN_RETENTION_MS = 5000;
  localparam int unsigned SEEN_RETENTION_CYCLES =
    SEEN_RETENTION_MS * (CLK_FREQ_HZ / 1000);
  localparam int TIMER_W = 32;
  // Command count after a write at which write-slot_advance_cmd is dropped
  localparam int WOK_CLEAR_CMDS = 2;
  localparam int WOK_CNT_W = 2;

endpackage : tsm_pkg

// File: inc/seen_timer_if.sv
`timescale 1ns/1ps
interface seen_timer_if;
  logic start;
  logic stop;
  logic expired;

  modport ctrl (
    output start,
    output stop,
    input expired
  );

  modport timer (
    input start,
    input stop,
    output expired
  );
endinterface : seen_timer_if

// File: rtl/flag_match.sv
`timescale 1ns/1ps
module flag_match (
  input wire logic [7:0] i_flags,
  input wire logic [7:0] i_mask,
  input wire logic [7:0] i_value,
  input wire tsm_pkg::cmp_t i_cmp,
  output logic o_valid_cmp,
  output logic o_match
);
  import tsm_pkg::*;

  logic equal;

  // Masked compare of the flag byte
  assign equal = ((i_flags ^ i_value) & i_mask) == 8'h00;

  always_comb begin
    o_valid_cmp = 1'b0;
    o_match = 1'b0;
    case (i_cmp)
      cmp_eq: begin
        o_valid_cmp = 1'b1;
        o_match = equal;
      end
      cmp_ne: begin
        o_valid_cmp = 1'b1;
        o_match = !equal;
      end
      default: begin
        o_valid_cmp = 1'b0;
        o_match = 1'b0;
      end
    endcase
  end
endmodule : flag_match

// File: rtl/seen_timer.sv
`timescale 1ns/1ps
module seen_timer #(
  parameter int unsigned RETENTION_CYCLES = tsm_pkg::SEEN_RETENTION_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  seen_timer_if.timer bus
);
  import tsm_pkg::*;

  localparam logic [TIMER_W-1:0] LAST =
    TIMER_W'(RETENTION_CYCLES - 1);

  typedef struct packed {
    logic running;
    logic [TIMER_W-1:0] count;
    logic expired;
  } timer_st_t;

  timer_st_t s_q;
  timer_st_t s_d;

  assign bus.expired = s_q.expired;

  always_comb begin
    s_d = s_q;
    s_d.expired = 1'b0;
    if (bus.stop) begin
      s_d.running = 1'b0;
      s_d.count = '0;
    end else if (bus.start) begin
      s_d.running = 1'b1;
      s_d.count = '0;
    end else if (s_q.running) begin
      if (s_q.count == LAST) begin
        s_d.running = 1'b0;
        s_d.expired = 1'b1;
      end else begin
        s_d.count = s_q.count + 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : seen_timer

// File: test/interrogator_model.sv
`timescale 1ns/1ps
module interrogator_model (
  input wire logic i_sys_clk,
  output logic o_field_present,
  output logic o_cmd_valid,
  output tsm_pkg::cmd_t o_cmd,
  output tsm_pkg::cmp_t o_cmp,
  output logic o_id_match,
  output logic o_data_eq,
  output logic o_data_gt,
  output logic o_bulk_data_match,
  output logic [7:0] o_flag_mask,
  output logic [7:0] o_flag_value,
  output logic o_prog_done,
  output logic o_prog_ok
);
  import tsm_pkg::*;

  // Field up and command port quiet from time zero
  initial begin
    o_field_present = 1'b1;
    o_cmd_valid = 1'b0;
    o_cmd = cmd_read;
    o_cmp = cmp_eq;
    {o_id_match, o_data_eq, o_data_gt, o_bulk_data_match} = 4'h0;
    {o_flag_mask, o_flag_value} = 16'h0000;
    o_prog_done = 1'b0;
    o_prog_ok = 1'b0;
  end

  // Compare variant and byte mask travel with the command
  task automatic send(input cmd_t c, input cmp_t p, input logic [3:0] q,
                      input logic [15:0] mv);
    @(posedge i_sys_clk);
    o_cmd_valid <= 1'b1;
    o_cmd <= c;
    o_cmp <= p;
    {o_id_match, o_data_eq, o_data_gt, o_bulk_data_match} <= q;
    {o_flag_mask, o_flag_value} <= mv;
    @(posedge i_sys_clk);
    o_cmd_valid <= 1'b0;
    // Qualifiers are stale now: invert so nothing leans on them
    {o_id_match, o_data_eq, o_data_gt, o_bulk_data_match} <= ~q;
  endtask : send

  task automatic prog(input logic ok);
    @(posedge i_sys_clk);
    o_prog_done <= 1'b1;
    o_prog_ok <= ok;
    @(posedge i_sys_clk);
    o_prog_done <= 1'b0;
    o_prog_ok <= ~ok;
  endtask : prog

  task automatic field(input logic v);
    @(posedge i_sys_clk);
    o_field_present <= v;
  endtask : field
endmodule : interrogator_model

// File: test/tag_state_machine_checker.sv
`timescale 1ns/1ps
module tag_state_machine_checker #(
  parameter int unsigned RETENTION_CYCLES = 20
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_field_present,
  input wire logic i_cmd_valid,
  input wire tsm_pkg::cmd_t i_cmd,
  input wire tsm_pkg::cmp_t i_cmp,
  input wire logic i_id_match,
  input wire logic i_data_eq,
  input wire logic i_data_gt,
  input wire logic i_bulk_data_match,
  input wire logic [7:0] i_flag_mask,
  input wire logic [7:0] i_flag_value,
  input wire logic i_prog_done,
  input wire logic i_prog_ok,
  input wire tsm_pkg::tag_state_t o_state,
  input wire logic [7:0] o_flag_byte,
  input wire logic o_cmd_taken,
  input wire logic o_cmd_ignored
);
  import tsm_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_pulse_has_cause: assert property (
    (o_cmd_taken || o_cmd_ignored) |->
    $past(i_cmd_valid) && !(o_cmd_taken && o_cmd_ignored))
    else $error("answer pulse without a command");
  a_upper_flags_zero: assert property (
    o_flag_byte[7:2] == 6'h0)
    else $error("reserved flag bits set");
  a_exchange_seen_set: assert property (
    o_state == st_exchange |-> o_flag_byte[0])
    else $error("seen bit clear in exchange");
  a_reinit_to_ready: assert property (
    i_field_present[*4] ##0 (i_cmd_valid && i_cmd == cmd_reinit
    && o_state != st_power_off) |=> o_state == st_ready && !o_flag_byte[0])
    else $error("reinit did not reach ready");
  a_read_id_ready: assert property (
    i_field_present[*4] ##0 (i_cmd_valid && i_cmd == cmd_read
    && o_state == st_ready) |=>
    o_state == ($past(i_id_match) ? st_exchange : st_ready))
    else $error("read in ready went wrong");
  a_verify_needs_wok: assert property (
    i_field_present[*4] ##0 (i_cmd_valid && i_cmd == quad_verify_read
    && o_state != st_exchange && !o_flag_byte[1]
    && o_state != st_power_off) |=> $stable(o_state))
    else $error("verify read moved without write slot_advance_cmd");
  a_flag_gtlt_refused: assert property (
    i_field_present[*4] ##0 (i_cmd_valid && i_cmd == group_select_by_flags
    && i_cmp[1] && o_state == st_ready) |=>
    o_cmd_ignored && o_state == st_ready)
    else $error("flag select with gt or lt acted on");
  a_ready_no_deselect: assert property (
    i_field_present[*4] ##0 (i_cmd_valid
    && i_cmd == group_deselect_by_data && o_state == st_ready) |=>
    o_cmd_ignored && o_state == st_ready)
    else $error("deselect acted on in ready");
  a_wok_after_prog: assert property (
    i_field_present[*4] ##0 (i_prog_done && i_prog_ok
    && o_state != st_power_off) |=> o_flag_byte[1])
    else $error("write slot_advance_cmd not set after programming");
  a_flag_deselect_hit: assert property (
    i_field_present[*4] ##0 (i_cmd_valid && i_cmd == group_deselect_by_flags
    && i_cmp == cmp_eq && o_state == identify_state
    && ((o_flag_byte ^ i_flag_value) & i_flag_mask) == 8'h00) |=>
    o_state == st_ready)
    else $error("matching flag deselect kept identify");
endmodule : tag_state_machine_checker

bind tag_state_machine tag_state_machine_checker #(
  .RETENTION_CYCLES(RETENTION_CYCLES)
) u_tag_state_machine_checker (.*);

// File: test/tag_state_machine_tb.sv
`timescale 1ns/1ps
module tag_state_machine_tb;
  import tsm_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic fld, vld, idm, deq, dgt, blk, pdn, pok;
  cmd_t cmd;
  cmp_t cmp;
  logic [7:0] msk, val, o_flag_byte;
  tag_state_t o_state;
  logic o_cmd_taken, o_cmd_ignored;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;

  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  interrogator_model u_interrogator_model (.i_sys_clk(i_sys_clk),
    .o_field_present(fld), .o_cmd_valid(vld), .o_cmd(cmd), .o_cmp(cmp),
    .o_id_match(idm), .o_data_eq(deq), .o_data_gt(dgt),
    .o_bulk_data_match(blk), .o_flag_mask(msk), .o_flag_value(val),
    .o_prog_done(pdn), .o_prog_ok(pok));

  // Short retention keeps the power-loss scenarios brief
  tag_state_machine #(.RETENTION_CYCLES(20)) u_tag_state_machine (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_field_present(fld),
    .i_cmd_valid(vld), .i_cmd(cmd), .i_cmp(cmp), .i_id_match(idm),
    .i_data_eq(deq), .i_data_gt(dgt), .i_bulk_data_match(blk),
    .i_flag_mask(msk), .i_flag_value(val), .i_prog_done(pdn),
    .i_prog_ok(pok), .o_state(o_state), .o_flag_byte(o_flag_byte),
    .o_cmd_taken(o_cmd_taken), .o_cmd_ignored(o_cmd_ignored));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic ex(input cmd_t c, input cmp_t p, input logic [3:0] q,
                    input logic [15:0] mv, input tag_state_t s,
                    input int tk);
    u_interrogator_model.send(c, p, q, mv);
    #1;
    chk("state", 8'(s), 8'(o_state));
    chk("taken", 8'(tk), 8'(o_cmd_taken));
    chk("ignored", 8'(!tk), 8'(o_cmd_ignored));
  endtask : ex

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    #1;
    chk("state", 8'(st_ready), 8'(o_state));
    chk("flags", 8'h00, o_flag_byte);
    ex(group_deselect_by_data, cmp_eq, 4'h4, 16'h0, st_ready, 0);
    ex(group_select_by_flags, cmp_gt, 4'h4, 16'h0, st_ready, 0);
    ex(group_select_by_data, cmp_eq, 4'h0, 16'h0, st_ready, 1);
    for (int i = 0; i < 4; i++) begin
      ex(group_select_by_data, cmp_t'(i), {1'b0, i == 0, i == 2, 1'b0},
         16'h0, identify_state, 1);
      ex(group_deselect_by_data, cmp_t'(i), {1'b0, i == 0, i == 2, 1'b0},
         16'h0, st_ready, 1);
    end
    ex(group_select_by_flags, cmp_eq, 4'h0, 16'h0100, identify_state,
       1);
    ex(group_deselect_by_flags, cmp_ne, 4'h0, 16'h0100, identify_state,
       1);
    ex(slot_advance_cmd, cmp_eq, 4'h0, 16'h0, identify_state, 1);
    ex(cmd_identified_read, cmp_eq, 4'h0, 16'h0, identify_state, 1);
    ex(cmd_identified_read, cmp_eq, 4'h8, 16'h0, st_exchange, 1);
    chk("flags", 8'h01, o_flag_byte);
    ex(cmd_protect, cmp_eq, 4'h0, 16'h0, st_exchange, 1);
    ex(cmd_reinit, cmp_eq, 4'h0, 16'h0, st_ready, 1);
    chk("flags", 8'h00, o_flag_byte);
    ex(quad_verify_read, cmp_eq, 4'h8, 16'h0, st_ready, 1);
    u_interrogator_model.prog(1'b1);
    #1;
    chk("flags", 8'h02, o_flag_byte);
    ex(quad_verify_read, cmp_eq, 4'h8, 16'h0, st_exchange, 1);
    chk("flags", 8'h03, o_flag_byte);
    ex(cmd_read, cmp_eq, 4'h8, 16'h0, st_exchange, 1);
    chk("flags", 8'h01, o_flag_byte);
    u_interrogator_model.field(1'b0);
    repeat (6) @(posedge i_sys_clk);
    u_interrogator_model.field(1'b1);
    repeat (6) @(posedge i_sys_clk);
    #1;
    chk("state", 8'(st_ready), 8'(o_state));
    chk("flags", 8'h01, o_flag_byte);
    // Seen bit is set now, so the flag value has a set bit to meet
    ex(group_select_by_flags, cmp_eq, 4'h0, 16'h0100, st_ready, 1);
    ex(group_select_by_flags, cmp_eq, 4'h0, 16'h0101, identify_state,
       1);
    ex(group_deselect_by_flags, cmp_eq, 4'h0, 16'h0101, st_ready,
       1);
    u_interrogator_model.field(1'b0);
    repeat (40) @(posedge i_sys_clk);
    u_interrogator_model.field(1'b1);
    repeat (6) @(posedge i_sys_clk);
    #1;
    chk("flags", 8'h00, o_flag_byte);
    ex(cmd_read, cmp_eq, 4'h8, 16'h0, st_exchange, 1);
    ex(cmd_reinit, cmp_eq, 4'h0, 16'h0, st_ready, 1);
    ex(group_select_by_data, cmp_eq, 4'h4, 16'h0, identify_state,
       1);
    u_interrogator_model.prog(1'b1);
    ex(cmd_bulk_write_deselect, cmp_eq, 4'h1, 16'h0, st_ready, 1);
    give_verdict();
  end
endmodule : tag_state_machine_tb
